// ===== rtl/scs_top.sv
// Clock source selection, switch sequencing and clock divisor registers
// Notes on behaviour
// - Start-up source comes from 3-bit configuration
// - Primary submode from 2-bit field, primary only
// - Erased device starts on divided internal RC
// - Bits 14:12 read back the active source
// - Bits 10:8 hold requested source, config reset
// - Freeze bit plus fail-safe bit locks settings
// - Bit 5 shows PLL lock, zero when disabled
// - Clock fail sets bit 3 when monitored; software or a switch start clears
// - Bit 1 enables the secondary oscillator
// - Switch request bit stays set until done
// - Recover bit: interrupt clears reduction, ratio 1:1
// - Reduction divides instruction clock by power two
// - Reduction enable off forces ratio 1:1
// - RC postscaler divides by 1..64, or 256
// - VCO divider 2, 4, 8; code 10 reserved
// - PLL prescaler divides by code plus two
// - Request for current source aborts, clears request
// - Wait ten new-clock cycles, then copy selection
// - Switching disabled: request held zero always
`timescale 1ns/100ps
`default_nettype none
module scs_top
    import scs_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic CFG_PROGRAMMED,
    input wire logic [2:0] CFG_STARTUP_SOURCE_SELECT,
    input wire logic [1:0] CFG_PRIMARY_SUBMODE_SELECT,
    input wire logic CFG_SWITCH_ENABLE_CONFIG,
    input wire logic CFG_FAILSAFE_CONFIG_BIT0,
    input wire logic [3:0] OSC_CLK_IN,
    input wire logic [3:0] OSC_STABLE_IN,
    input wire logic PLL_LOCK_IN,
    input wire logic FAILSAFE_MONITOR_FAIL,
    input wire logic INTERRUPT_EVENT,
    output logic [3:0] OSC_ENABLE,
    output logic PLL_ENABLE,
    output logic [1:0] PRIMARY_SUBMODE,
    output logic [2:0] CURRENT_SOURCE,
    output logic SWITCH_BUSY,
    output logic SYS_CLK_EN,
    output logic INSTR_CLK_EN,
    output logic CPU_CLK_EN,
    output logic FRC_POSTSCALED_EN,
    output logic [5:0] PLL_PRESCALE_N1,
    output logic [3:0] PLL_POSTSCALE_N2
);
    // Divider hit: counter at or past 2^lg - 1, so a shortened ratio takes effect at once
    function automatic logic div_hit(input logic [7:0] cnt, input logic [3:0] lg);
        logic [8:0] full;
        full = (9'h001 << lg) - 9'h001;
        div_hit = (cnt >= full[7:0]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: oscillator clocks, stable flags, lock, fail
    logic [9:0] pin_q, pin_rise;
    scs_sync #(.W(10)) u_sync (
        .clk(REF_CLK),
        .rst(RST),
        .d({FAILSAFE_MONITOR_FAIL, PLL_LOCK_IN, OSC_STABLE_IN, OSC_CLK_IN}),
        .q(pin_q),
        .rise(pin_rise)
    );
    logic [3:0] osc_rise, osc_stable;
    logic pll_lock_s, fail_rise;
    assign osc_rise = pin_rise[3:0];
    assign osc_stable = pin_q[7:4];
    assign pll_lock_s = pin_q[8];
    assign fail_rise = pin_rise[9];

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait state, read data stands while waitrequest is low
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic key1_reg, key1_next, armed_reg, armed_next;
    logic wr_take, wr_osc, wr_div, wr_unl, osc_wr_ok;
    logic [15:0] osc_word, div_word;

    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
    assign wr_take = AVS_WRITE & ack_reg;
    assign wr_osc = wr_take && (AVS_ADDRESS == ADDR_OSC_CTRL);
    assign wr_div = wr_take && (AVS_ADDRESS == ADDR_CLK_DIV);
    assign wr_unl = wr_take && (AVS_ADDRESS == ADDR_UNLOCK);
    assign osc_wr_ok = wr_osc & armed_reg;

    always_comb begin
        ack_next = (AVS_READ | AVS_WRITE) & ~ack_reg;
        rdata_next = rdata_reg;
        if (AVS_READ && !ack_reg) begin
            case (AVS_ADDRESS)
                ADDR_OSC_CTRL: rdata_next = {16'h0000, osc_word};
                ADDR_CLK_DIV: rdata_next = {16'h0000, div_word};
                ADDR_UNLOCK: rdata_next = {30'h0, armed_reg, key1_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
        // Key pair arms exactly one control write; a further unlock write disarms, other accesses do not
        key1_next = key1_reg;
        armed_next = armed_reg;
        if (wr_unl && AVS_BYTEENABLE[0]) begin
            key1_next = (AVS_WRITEDATA[7:0] == UNLOCK_KEY1);
            armed_next = key1_reg && (AVS_WRITEDATA[7:0] == UNLOCK_KEY2);
        end else if (wr_osc) begin
            key1_next = 1'b0;
            armed_next = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            key1_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            key1_reg <= key1_next;
            armed_reg <= armed_next;
        end
    end
    assign AVS_READDATA = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator control and switch sequencer
    scs_sw_state_e state_reg, state_next;
    logic [2:0] current_source_reg, current_source_next, new_source_reg, new_source_next;
    logic [1:0] sub_reg;
    logic freeze_reg, freeze_next, cf_reg, cf_next, sec_reg, sec_next;
    logic swreq_reg, swreq_next;
    logic [3:0] settle_reg, settle_next;
    logic [3:0] osc_en_next;
    logic pll_en_reg, pll_en_next, sys_en_reg, sys_en_next;
    logic sw_enabled, monitor_en, frozen, new_ready, lock_bit, busy;
    logic [2:0] boot_src;

    assign boot_src = CFG_PROGRAMMED ? CFG_STARTUP_SOURCE_SELECT : SRC_ERASED;
    assign sw_enabled = ~CFG_SWITCH_ENABLE_CONFIG;
    assign monitor_en = sw_enabled & ~CFG_FAILSAFE_CONFIG_BIT0;
    assign frozen = freeze_reg & CFG_FAILSAFE_CONFIG_BIT0;
    assign busy = (state_reg == SW_WAIT) || (state_reg == SW_COUNT);
    // PLL sources also need lock before the settle count starts
    assign new_ready = osc_stable[src_osc(new_source_reg)] && (!src_uses_pll(new_source_reg) || pll_lock_s);
    assign lock_bit = pll_lock_s & pll_en_reg;
    assign osc_word = {1'b0, current_source_reg, 1'b0, new_source_reg, freeze_reg, 1'b0, lock_bit, 1'b0,
                       cf_reg, 1'b0, sec_reg, swreq_reg};

    always_comb begin
        state_next = state_reg;
        current_source_next = current_source_reg;
        new_source_next = new_source_reg;
        freeze_next = freeze_reg;
        cf_next = cf_reg;
        sec_next = sec_reg;
        swreq_next = swreq_reg;
        settle_next = settle_reg;
        // Byte-lane writes behind the unlock
        if (osc_wr_ok && AVS_BYTEENABLE[1] && !frozen && sw_enabled && state_reg == SW_IDLE) begin
            new_source_next = AVS_WRITEDATA[OC_NEW_SOURCE_LSB +: 3];
        end
        if (osc_wr_ok && AVS_BYTEENABLE[0]) begin
            if (!frozen) begin
                freeze_next = AVS_WRITEDATA[OC_FREEZE_BIT];
            end
            sec_next = AVS_WRITEDATA[OC_SEC_BIT];
            if (!AVS_WRITEDATA[OC_CF_BIT]) begin
                cf_next = 1'b0;
            end
            if (AVS_WRITEDATA[OC_SWREQ_BIT] && !frozen && state_reg == SW_IDLE) begin
                swreq_next = 1'b1;
            end
        end
        case (state_reg)
            SW_IDLE: begin
                if (swreq_reg) begin
                    state_next = SW_CHECK;
                end
            end
            SW_CHECK: begin
                if (new_source_reg == current_source_reg) begin
                    swreq_next = 1'b0;
                    state_next = SW_IDLE;
                end else begin
                    cf_next = 1'b0;
                    state_next = SW_WAIT;
                end
            end
            SW_WAIT: begin
                settle_next = 4'h0;
                if (new_ready) begin
                    state_next = SW_COUNT;
                end
            end
            SW_COUNT: begin
                // Change over on a new-source edge so no partial period is seen
                if (osc_rise[src_osc(new_source_reg)]) begin
                    settle_next = settle_reg + 4'h1;
                    if (settle_reg == SETTLE_CYCLES - 4'h1) begin
                        current_source_next = new_source_reg;
                        swreq_next = 1'b0;
                        state_next = SW_IDLE;
                    end
                end
            end
            default: state_next = SW_IDLE;
        endcase
        // Hardware fail event wins over a clear in the same cycle
        if (fail_rise && monitor_en) begin
            cf_next = 1'b1;
        end
        if (!sw_enabled) begin
            swreq_next = 1'b0;
            state_next = SW_IDLE;
        end
        osc_en_next = 4'h0;
        osc_en_next[src_osc(current_source_reg)] = 1'b1;
        if (busy) begin
            osc_en_next[src_osc(new_source_reg)] = 1'b1;
        end
        if (sec_reg) begin
            osc_en_next[OSC_SEC] = 1'b1;
        end
        pll_en_next = src_uses_pll(current_source_reg) || (busy && src_uses_pll(new_source_reg));
        sys_en_next = osc_rise[src_osc(current_source_reg)];
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_reg <= SW_IDLE;
            current_source_reg <= boot_src;
            new_source_reg <= boot_src;
            sub_reg <= CFG_PRIMARY_SUBMODE_SELECT;
            freeze_reg <= 1'b0;
            cf_reg <= 1'b0;
            sec_reg <= 1'b0;
            swreq_reg <= 1'b0;
            settle_reg <= 4'h0;
            OSC_ENABLE <= 4'h0;
            pll_en_reg <= 1'b0;
            sys_en_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            current_source_reg <= current_source_next;
            new_source_reg <= new_source_next;
            freeze_reg <= freeze_next;
            cf_reg <= cf_next;
            sec_reg <= sec_next;
            swreq_reg <= swreq_next;
            settle_reg <= settle_next;
            OSC_ENABLE <= osc_en_next;
            pll_en_reg <= pll_en_next;
            sys_en_reg <= sys_en_next;
        end
    end
    assign PLL_ENABLE = pll_en_reg;
    assign CURRENT_SOURCE = current_source_reg;
    assign SWITCH_BUSY = swreq_reg;
    assign SYS_CLK_EN = sys_en_reg;
    // Submode only matters for primary sources
    assign PRIMARY_SUBMODE = (src_osc(current_source_reg) == OSC_PRI) ? sub_reg : SUB_EC;

    ////////////////////////////////////////////////////////////////////////
    // Clock divisor register; not behind the unlock
    logic roi_reg, roi_next, reduction_enable_reg, reduction_enable_next;
    logic [2:0] cpu_clock_reduction_reg, cpu_clock_reduction_next, internal_rc_postscaler_reg, internal_rc_postscaler_next;
    logic [1:0] post_reg, post_next;
    logic [4:0] pre_reg, pre_next;
    assign div_word = {roi_reg, cpu_clock_reduction_reg, reduction_enable_reg, internal_rc_postscaler_reg, post_reg, 1'b0, pre_reg};

    always_comb begin
        roi_next = roi_reg;
        cpu_clock_reduction_next = cpu_clock_reduction_reg;
        reduction_enable_next = reduction_enable_reg;
        internal_rc_postscaler_next = internal_rc_postscaler_reg;
        post_next = post_reg;
        pre_next = pre_reg;
        if (wr_div && AVS_BYTEENABLE[1]) begin
            roi_next = AVS_WRITEDATA[CD_ROI_BIT];
            cpu_clock_reduction_next = AVS_WRITEDATA[CD_CPU_CLOCK_REDUCTION_LSB +: 3];
            reduction_enable_next = AVS_WRITEDATA[CD_REDUCTION_ENABLE_BIT];
            if (!frozen) begin
                internal_rc_postscaler_next = AVS_WRITEDATA[CD_INTERNAL_RC_POSTSCALER_LSB +: 3];
            end
        end
        if (wr_div && AVS_BYTEENABLE[0] && !frozen) begin
            // Reserved divider code is refused, old value kept
            if (AVS_WRITEDATA[CD_POST_LSB +: 2] != POST_RESERVED) begin
                post_next = AVS_WRITEDATA[CD_POST_LSB +: 2];
            end
            pre_next = AVS_WRITEDATA[CD_PRE_LSB +: 5];
        end
        if (roi_reg && INTERRUPT_EVENT) begin
            reduction_enable_next = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            roi_reg <= 1'b0;
            cpu_clock_reduction_reg <= CPU_CLOCK_REDUCTION_RESET;
            reduction_enable_reg <= 1'b0;
            internal_rc_postscaler_reg <= INTERNAL_RC_POSTSCALER_RESET;
            post_reg <= POST_RESET;
            pre_reg <= PRE_RESET;
        end else begin
            roi_reg <= roi_next;
            cpu_clock_reduction_reg <= cpu_clock_reduction_next;
            reduction_enable_reg <= reduction_enable_next;
            internal_rc_postscaler_reg <= internal_rc_postscaler_next;
            post_reg <= post_next;
            pre_reg <= pre_next;
        end
    end
    assign PLL_PRESCALE_N1 = {1'b0, pre_reg} + 6'h02;
    assign PLL_POSTSCALE_N2 = (post_reg == 2'h0) ? 4'h2 : ((post_reg == 2'h1) ? 4'h4 : 4'h8);

    ////////////////////////////////////////////////////////////////////////
    // Enable dividers: instruction = system/2, cpu = instruction/2^ratio
    logic half_reg, half_next, instr_reg, instr_next, cpu_reg, cpu_next, frc_reg, frc_next;
    logic [7:0] cpu_cnt_reg, cpu_cnt_next, frc_cnt_reg, frc_cnt_next;
    logic [2:0] ratio;
    logic [3:0] frc_lg;
    assign ratio = reduction_enable_reg ? cpu_clock_reduction_reg : 3'h0;
    assign frc_lg = (internal_rc_postscaler_reg == INTERNAL_RC_POSTSCALER_MAX) ? 4'h8 : {1'b0, internal_rc_postscaler_reg};

    always_comb begin
        half_next = half_reg ^ sys_en_reg;
        instr_next = sys_en_reg & half_reg;
        cpu_next = 1'b0;
        cpu_cnt_next = cpu_cnt_reg;
        if (instr_reg) begin
            cpu_cnt_next = cpu_cnt_reg + 8'h01;
            // A ratio cut below the count restarts at the next instruction tick
            if (div_hit(cpu_cnt_reg, {1'b0, ratio})) begin
                cpu_next = 1'b1;
                cpu_cnt_next = 8'h00;
            end
        end
        frc_next = 1'b0;
        frc_cnt_next = frc_cnt_reg;
        if (osc_rise[OSC_FRC]) begin
            frc_cnt_next = frc_cnt_reg + 8'h01;
            if (div_hit(frc_cnt_reg, frc_lg)) begin
                frc_next = 1'b1;
                frc_cnt_next = 8'h00;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            half_reg <= 1'b0;
            instr_reg <= 1'b0;
            cpu_reg <= 1'b0;
            frc_reg <= 1'b0;
            cpu_cnt_reg <= 8'h00;
            frc_cnt_reg <= 8'h00;
        end else begin
            half_reg <= half_next;
            instr_reg <= instr_next;
            cpu_reg <= cpu_next;
            frc_reg <= frc_next;
            cpu_cnt_reg <= cpu_cnt_next;
            frc_cnt_reg <= frc_cnt_next;
        end
    end
    assign INSTR_CLK_EN = instr_reg;
    assign CPU_CLK_EN = cpu_reg;
    assign FRC_POSTSCALED_EN = frc_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    a_erased_boot: assert property ($past(RST) && !$past(CFG_PROGRAMMED) |-> current_source_reg == SRC_FRC_DIVN)
        else $error("erased device did not boot on divided RC");
    a_current_source_readback: assert property (AVS_READ && !ack_reg && AVS_ADDRESS == ADDR_OSC_CTRL
        |=> AVS_READDATA[OC_CURRENT_SOURCE_LSB +: 3] == $past(current_source_reg) && !AVS_WAITREQUEST)
        else $error("current source readback wrong");
    a_locked_write: assert property (wr_osc && !armed_reg |=> $stable(new_source_reg) && $stable(sec_reg))
        else $error("control write without unlock took effect");
    a_freeze_hold: assert property (osc_wr_ok && frozen |=> $stable(new_source_reg) && freeze_reg)
        else $error("frozen settings changed");
    a_cf_set: assert property (fail_rise && monitor_en |=> cf_reg)
        else $error("clock fail not flagged");
    a_redundant_abort: assert property (state_reg == SW_CHECK && new_source_reg == current_source_reg
        |=> !swreq_reg && state_reg == SW_IDLE)
        else $error("redundant switch not aborted");
    a_switch_settle: assert property ($changed(current_source_reg) |-> $past(state_reg) == SW_COUNT
        && $past(settle_reg) == 4'h9 && !swreq_reg)
        else $error("changeover without ten new-clock edges");
    a_switch_off: assert property (CFG_SWITCH_ENABLE_CONFIG |=> !swreq_reg)
        else $error("request bit set while switching disabled");
    a_roi_clear: assert property (roi_reg && INTERRUPT_EVENT |=> !reduction_enable_reg)
        else $error("interrupt did not clear reduction enable");
    a_ratio_one: assert property (instr_reg && ratio == 3'h0 |=> CPU_CLK_EN)
        else $error("1:1 ratio missed a cpu tick");
    a_post_legal: assert property (post_reg != POST_RESERVED)
        else $error("reserved vco divider code stored");
    a_lock_off: assert property (!pll_en_reg |-> !osc_word[OC_LOCK_BIT])
        else $error("lock reported with pll disabled");

    c_switch_done: cover property ($changed(current_source_reg));
    c_redundant: cover property (state_reg == SW_CHECK && new_source_reg == current_source_reg);
    c_cf_flag: cover property ($rose(cf_reg));
    c_roi: cover property (roi_reg && INTERRUPT_EVENT && reduction_enable_reg);
endmodule
`default_nettype wire

// ===== rtl/scs_pkg.sv
// Shared constants, types and source-decode helpers for the clock select and divide block
package scs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses on the slave port
    localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CLK_DIV = 4'h4;
    localparam logic [3:0] ADDR_UNLOCK = 4'h8;

    // Unlock keys, written in this order to the unlock register
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator control field positions
    localparam int OC_CURRENT_SOURCE_LSB = 12;
    localparam int OC_NEW_SOURCE_LSB = 8;
    localparam int OC_FREEZE_BIT = 7;
    localparam int OC_LOCK_BIT = 5;
    localparam int OC_CF_BIT = 3;
    localparam int OC_SEC_BIT = 1;
    localparam int OC_SWREQ_BIT = 0;

    // Clock divisor field positions and reset values
    localparam int CD_ROI_BIT = 15;
    localparam int CD_CPU_CLOCK_REDUCTION_LSB = 12;
    localparam int CD_REDUCTION_ENABLE_BIT = 11;
    localparam int CD_INTERNAL_RC_POSTSCALER_LSB = 8;
    localparam int CD_POST_LSB = 6;
    localparam int CD_PRE_LSB = 0;
    localparam logic [2:0] CPU_CLOCK_REDUCTION_RESET = 3'h3;
    localparam logic [2:0] INTERNAL_RC_POSTSCALER_RESET = 3'h0;
    localparam logic [1:0] POST_RESET = 2'h1;
    localparam logic [4:0] PRE_RESET = 5'h00;
    localparam logic [1:0] POST_RESERVED = 2'h2;
    localparam logic [2:0] INTERNAL_RC_POSTSCALER_MAX = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Source selection codes
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_INTERNAL_OSC = 3'h5;
    localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_FRC_DIVN = 3'h7;
    localparam logic [2:0] SRC_ERASED = SRC_FRC_DIVN;

    // Primary submodes
    localparam logic [1:0] SUB_HS = 2'h2;
    localparam logic [1:0] SUB_XT = 2'h1;
    localparam logic [1:0] SUB_EC = 2'h0;

    // Physical oscillator index
    localparam logic [1:0] OSC_FRC = 2'h0;
    localparam logic [1:0] OSC_PRI = 2'h1;
    localparam logic [1:0] OSC_SEC = 2'h2;
    localparam logic [1:0] OSC_LOW_POWER_INTERNAL_OSC = 2'h3;

    // New-clock cycles to wait before changeover
    localparam logic [3:0] SETTLE_CYCLES = 4'hA;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_CHECK = 2'b01,
        SW_WAIT = 2'b10,
        SW_COUNT = 2'b11
    } scs_sw_state_e;

    // Oscillator that feeds a given source code
    function automatic logic [1:0] src_osc(input logic [2:0] code);
        case (code)
            SRC_PRI, SRC_PRI_PLL: src_osc = OSC_PRI;
            SRC_SEC: src_osc = OSC_SEC;
            SRC_LOW_POWER_INTERNAL_OSC: src_osc = OSC_LOW_POWER_INTERNAL_OSC;
            default: src_osc = OSC_FRC;
        endcase
    endfunction

    function automatic logic src_uses_pll(input logic [2:0] code);
        src_uses_pll = (code == SRC_FRC_PLL) || (code == SRC_PRI_PLL);
    endfunction

endpackage

// ===== rtl/scs_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
`default_nettype none
module scs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg, rise_reg;
    logic [W-1:0] q_next, rise_next;

    ////////////////////////////////////////////////////////////////////////
    // Accept a new level only when stages two and three agree
    always_comb begin
        q_next = (s2_reg & s3_reg) | (q_reg & (s2_reg | s3_reg));
        rise_next = q_next & ~q_reg;
    end

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
            rise_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
            rise_reg <= rise_next;
        end
    end

    assign q = q_reg;
    assign rise = rise_reg;
endmodule
`default_nettype wire

// ===== bench/tb_scs_top.sv
// Self-checking bench for the clock select and divide block
`timescale 1ns/100ps
`default_nettype none
module tb_scs_top import scs_pkg::*;;
logic clk = 1'b0;
logic rst = 1'b1;
logic rd = 1'b0, wr = 1'b0, intr = 1'b0, fail = 1'b0, lock = 1'b0;
logic prog = 1'b1, swoff = 1'b0, fsb0 = 1'b0, pe, sb, ins, cpu, frc;
logic [1:0] sm;
logic [3:0] adr = 4'h0, be = 4'hF, osc = 4'h0, stab = 4'h0;
logic [31:0] wd = 32'h0, rdq, rdata;
logic [15:0] d;
logic wq;
logic [2:0] cur;
logic [5:0] n1;
logic [3:0] n2, oen;
int err_count = 0, samples_checked = 0, cyc = 0, seed = 94, div_m = 'h3040, p;
////////////////////////////////////////////////////////////////////////
// Clock, slow oscillator pins and the hang limit
always #12.5 clk = ~clk;
always @(posedge clk) begin
    cyc <= cyc + 1;
    osc <= {4{cyc[2]}}; // Each level lasts 4 cycles, above the filter minimum
    if (cyc == 30000) begin
        err_count++;
        stop_test();
    end
end
scs_top i_scs_top (.REF_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdq), .AVS_WAITREQUEST(wq),
    .CFG_PROGRAMMED(prog), .CFG_STARTUP_SOURCE_SELECT(SRC_FRC), .CFG_PRIMARY_SUBMODE_SELECT(SUB_HS),
    .CFG_SWITCH_ENABLE_CONFIG(swoff), .CFG_FAILSAFE_CONFIG_BIT0(fsb0), .OSC_CLK_IN(osc),
    .OSC_STABLE_IN(stab), .PLL_LOCK_IN(lock), .FAILSAFE_MONITOR_FAIL(fail), .INTERRUPT_EVENT(intr),
    .OSC_ENABLE(oen), .PLL_ENABLE(pe), .PRIMARY_SUBMODE(sm), .CURRENT_SOURCE(cur), .SWITCH_BUSY(sb),
    .SYS_CLK_EN(), .INSTR_CLK_EN(ins), .CPU_CLK_EN(cpu), .FRC_POSTSCALED_EN(frc),
    .PLL_PRESCALE_N1(n1), .PLL_POSTSCALE_N2(n2));
////////////////////////////////////////////////////////////////////////
// Bus access held until waitrequest is sampled low, then one idle edge
task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] dd, input logic [3:0] b);
    wr <= w;
    rd <= ~w;
    adr <= a;
    be <= b;
    wd <= {16'h0, dd};
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    rdata = rdq;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
endtask
// Control write preceded by the two unlock keys
task automatic ocw(input logic [15:0] dd, input logic [3:0] b);
    xfer(1'b1, ADDR_UNLOCK, {8'h00, UNLOCK_KEY1}, 4'h1);
    xfer(1'b1, ADDR_UNLOCK, {8'h00, UNLOCK_KEY2}, 4'h1);
    xfer(1'b1, ADDR_OSC_CTRL, dd, b);
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
        err_count++;
        $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 16'h0, 4'hF);
    chk(rdata, exp);
endtask
// Instruction ticks from one cpu tick to the next
task automatic cpugap(input int exp);
    @(posedge clk iff cpu === 1'b1);
    p = 0;
    do begin
        @(posedge clk);
        p += int'(ins === 1'b1);
    end while (cpu !== 1'b1 && p < 200);
    chk(p, exp);
endtask
// Divisor model: bit 5 reads zero, reserved divider code keeps the old one
function automatic int divw(input int old, input int v);
    divw = v & 'hFFDF;
    if (((v >> 6) & 3) == 2) divw = (divw & 'hFF3F) | (old & 'h00C0);
endfunction
task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) begin
        $display("NO MISMATCHES");
    end else begin
        $display("MISMATCHES SEEN");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
// Main sequence
initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(ADDR_OSC_CTRL, 32'h0);
    rdchk(ADDR_CLK_DIV, 32'h3040);
    rdchk(4'hC, 32'h0);
    xfer(1'b1, ADDR_OSC_CTRL, 16'h0002, 4'hF);
    rdchk(ADDR_OSC_CTRL, 32'h0);
    ocw(16'h0002, 4'hF);
    rdchk(ADDR_OSC_CTRL, 32'h2);
    ocw(16'h0003, 4'h1);
    repeat (2) @(posedge clk);
    rdchk(ADDR_OSC_CTRL, 32'h2);
    chk({30'h0, sm}, {30'h0, SUB_EC});
    // Primary with multiplier, not yet stable or locked, so the request must stay pending
    ocw(16'h0300, 4'h2); // Starts from plain RC, never a multiplier-to-multiplier hop
    ocw(16'h0303, 4'h1);
    rdchk(ADDR_OSC_CTRL, 32'h0303);
    chk({26'h0, oen, pe, sb}, 32'h1F);
    stab <= 4'hF;
    lock <= 1'b1;
    for (int i = 0; i < 80 && rdata[0] !== 1'b0; i++) xfer(1'b0, ADDR_OSC_CTRL, 16'h0, 4'hF);
    chk(rdata, 32'h3322);
    chk({29'h0, cur}, {29'h0, SRC_PRI_PLL});
    chk({26'h0, oen, pe, sb}, 32'h1A);
    chk({30'h0, sm}, {30'h0, SUB_HS});
    fail <= 1'b1;
    repeat (8) @(posedge clk);
    fail <= 1'b0;
    rdchk(ADDR_OSC_CTRL, 32'h332A);
    ocw(16'h3322, 4'h1);
    rdchk(ADDR_OSC_CTRL, 32'h3322);
    // Random divisor values, the first one with the reserved divider code
    for (int i = 0; i < 8; i++) begin
        d = 16'($random(seed));
        if (i == 0) d[7:6] = 2'h2;
        d[15] = 1'b0;
        xfer(1'b1, ADDR_CLK_DIV, d, 4'h3);
        div_m = divw(div_m, int'(d));
        rdchk(ADDR_CLK_DIV, div_m);
        p = (div_m >> 6) & 3;
        chk({22'h0, n1, n2}, (((div_m & 31) + 2) << 4) | (p == 3 ? 8 : 2 << p));
    end
    // Ratio 1:8 with recovery armed, RC postscaler divide by 4
    xfer(1'b1, ADDR_CLK_DIV, 16'hBA00, 4'h3);
    cpugap(8);
    @(posedge clk iff frc === 1'b1);
    p = 0;
    do begin
        @(posedge clk);
        p++;
    end while (frc !== 1'b1 && p < 999);
    chk(p, 32); // Four internal RC rises of eight cycles each
    intr <= 1'b1;
    @(posedge clk);
    intr <= 1'b0;
    rdchk(ADDR_CLK_DIV, 32'hB200);
    cpugap(1);
    // Mid-run reset as an erased part with switching off and freeze honoured
    rst <= 1'b1;
    prog <= 1'b0;
    swoff <= 1'b1;
    fsb0 <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({29'h0, cur}, {29'h0, SRC_FRC_DIVN});
    ocw(16'h0001, 4'h1);
    rdchk(ADDR_OSC_CTRL, 32'h7700);
    chk({26'h0, oen, pe, sb}, 32'h04);
    ocw(16'h0080, 4'h1);
    ocw(16'h0000, 4'h3);
    rdchk(ADDR_OSC_CTRL, 32'h7780);
    xfer(1'b1, ADDR_CLK_DIV, 16'h07FF, 4'h3);
    rdchk(ADDR_CLK_DIV, 32'h0040);
    stop_test();
end
endmodule
`default_nettype wire
